// >>> design/ctu_pin_sync.sv
// Two-flop synchroniser with edge detection for the timer pins
`timescale 1ns/1ns
module ctu_pin_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Raw pins
   input wire logic [WIDTH-1:0] pin_i,
   // Synchronised level and edges
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] last;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
   } ctu_sync_state_s;

   ctu_sync_state_s st;
   ctu_sync_state_s next_st;

   // First flop feeds only the second; edges compare second and third
   always_comb begin
      next_st = st;
      next_st.meta = pin_i;
      next_st.sync = st.meta;
      next_st.last = st.sync;
      next_st.rise = st.sync & ~st.last;
      next_st.fall = ~st.sync & st.last;
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_o = st.last;
   assign rise_o = st.rise;
   assign fall_o = st.fall;

endmodule

// >>> design/ctu_pkg.sv
// Package of constants and types for the capture timer unit
package ctu_pkg;

   // ***************************************************************
   // Register map (word addresses)
   // ***************************************************************
   localparam logic [3:0] CTU_ADDR_CTRL = 4'h0;
   localparam logic [3:0] CTU_ADDR_STATUS = 4'h1;
   localparam logic [3:0] CTU_ADDR_COUNT = 4'h2;
   localparam logic [3:0] CTU_ADDR_LIMIT = 4'h3;
   localparam logic [3:0] CTU_ADDR_CAPTURE = 4'h4;
   localparam logic [3:0] CTU_ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] CTU_ADDR_IRQ_MASK = 4'h6;

   // ***************************************************************
   // Widths and field positions
   // ***************************************************************
   localparam int CTU_ADDR_W = 4;
   localparam int CTU_DATA_W = 16;
   localparam int CTU_CTRL_W = 13;
   localparam int CTU_IRQ_W = 3;
   localparam int CTU_TASK_W = 4;
   localparam int CTU_POS_TASK_SEL = 0;
   localparam int CTU_POS_ENABLE = 3;
   localparam int CTU_POS_CLK_EXT = 4;
   localparam int CTU_POS_PRESC = 5;
   localparam int CTU_POS_MODE = 7;
   localparam int CTU_POS_COUNT_EVENT_FLAG = 0;
   localparam int CTU_POS_WRAP_FLAG = 1;
   localparam int CTU_IRQ_EVENT = 0;
   localparam int CTU_IRQ_WRAP = 1;
   localparam int CTU_IRQ_CAPTURE = 2;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [12:0] CTU_RST_CTRL = 13'h0000;
   localparam logic [15:0] CTU_RST_COUNT = 16'h0000;
   localparam logic [15:0] CTU_RST_LIMIT = 16'hffff;
   localparam logic [15:0] CTU_RST_CAPTURE = 16'h0000;
   localparam logic [2:0] CTU_RST_IRQ_MASK = 3'h0;

   // ***************************************************************
   // Timing: internal count rate made from the 250 MHz clock
   // ***************************************************************
   localparam int CTU_CLK_RATE_KHZ = 250000;
   localparam int CTU_INT_RATE_KHZ = 28700;
   localparam int CTU_EXT_MAX_RATE_KHZ = 600;
   localparam int CTU_ACC_W = 18;
   localparam logic [17:0] CTU_ACC_STEP = 18'(CTU_INT_RATE_KHZ);
   localparam logic [17:0] CTU_ACC_MOD = 18'(CTU_CLK_RATE_KHZ);
   localparam int CTU_PRE_W = 6;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      CTU_MODE_FREE = 2'b00,
      CTU_MODE_CAP_RISE = 2'b01,
      CTU_MODE_CAP_FALL = 2'b10,
      CTU_MODE_FREE_ALT = 2'b11
   } ctu_mode_e;

   typedef struct packed {
      logic [3:0] spare;
      ctu_mode_e mode;
      logic [1:0] presc;
      logic clk_ext;
      logic enable;
      logic [2:0] event_task_select;
   } ctu_ctrl_s;

   typedef struct packed {
      logic [CTU_ADDR_W-1:0] addr;
      logic [CTU_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ctu_bus_req_s;

endpackage

// >>> design/ctu_timer.sv
// Capture timer unit: counter, prescaler, capture, flags and register port
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

// Overview of operation
// RL1: 16-bit counter increments per selected tick
// RL2: Control bit 3 enables counting
// RL3: Control bit 4 selects external clock pin
// RL4: Internal rate divided by 1/4/16/64
// RL5: External clock stays at or below 600kHz
// RL6: Free-running mode flags event on wrap
// RL7: Mode 1 captures count on rising edge
// RL8: Mode 2 captures count on falling edge
// RL9: Capture modes keep counting, no wrap event
// RL10: Event flag requests selected event task
// RL11: Event flag auto-clears or clears on read
// RL12: Wrap flag sets always, clears on read
// RL13: Live count readable and writable anytime
// RL14: Counter wraps at programmed limit value
// RL15: Avoid small limit with fast clock
// RL16: Reload zero after limit; mode 3 free
module ctu_timer #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [ctu_pkg::CTU_ADDR_W-1:0] addr_i,
   input wire logic [ctu_pkg::CTU_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [ctu_pkg::CTU_DATA_W-1:0] rd_data_o,
   // Pins
   input wire logic capture_input_pin_i,
   input wire logic external_clock_pin_i,
   // Event task requests and interrupt
   output logic [ctu_pkg::CTU_TASK_W-1:0] event_task_req_o,
   output logic irq_o
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      ctu_pkg::ctu_ctrl_s ctrl;
      logic count_event_flag;
      logic wrap_flag;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] limit;
      logic [CNT_W-1:0] capture;
      logic [ctu_pkg::CTU_IRQ_W-1:0] irq_stat;
      logic [ctu_pkg::CTU_IRQ_W-1:0] irq_mask;
      logic [ctu_pkg::CTU_ACC_W-1:0] acc;
      logic [ctu_pkg::CTU_PRE_W-1:0] pre;
      logic [ctu_pkg::CTU_DATA_W-1:0] rd_data;
      logic [ctu_pkg::CTU_TASK_W-1:0] task_req;
      logic irq;
   } ctu_state_s;

   // Registered state and its next value
   ctu_state_s st;
   ctu_state_s next_st;
   ctu_pkg::ctu_bus_req_s req;

   // Synchronised pin edges, bit 0 capture and bit 1 external clock
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;

   // ***************************************************************
   // Functions
   // ***************************************************************

   // Prescaler mask: all-ones low bits mark the divided tick
   function automatic logic [ctu_pkg::CTU_PRE_W-1:0] presc_mask(input logic [1:0] sel);
      logic [ctu_pkg::CTU_PRE_W-1:0] m;
      m = '0;
      case (sel)
         2'h0: m = 6'h00;
         2'h1: m = 6'h03;
         2'h2: m = 6'h0f;
         2'h3: m = 6'h3f;
         default: m = 6'h00;
      endcase
      return m;
   endfunction

   // One-hot event task request from the selector
   function automatic logic [ctu_pkg::CTU_TASK_W-1:0] task_decode(input logic [2:0] sel);
      logic [ctu_pkg::CTU_TASK_W-1:0] t;
      t = '0;
      case (sel)
         3'h1: t = 4'h1;
         3'h2: t = 4'h2;
         3'h3: t = 4'h4;
         3'h4: t = 4'h8;
         default: t = 4'h0;
      endcase
      return t;
   endfunction

   // Free-running modes, the spare code included
   function automatic logic is_free_mode(input ctu_pkg::ctu_mode_e m);
      return (m == ctu_pkg::CTU_MODE_FREE) || (m == ctu_pkg::CTU_MODE_FREE_ALT);
   endfunction

   // Register address decode
   function automatic logic hit(input logic [ctu_pkg::CTU_ADDR_W-1:0] a,
                                input logic [ctu_pkg::CTU_ADDR_W-1:0] reg_addr);
      return a == reg_addr;
   endfunction

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************

   // Bit 0 is the capture pin, bit 1 the external clock pin
   // Only the edges are used; the level output is left open
   ctu_pin_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i({external_clock_pin_i, capture_input_pin_i}),
      .level_o(),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   // Bus request bundle
   assign req.addr = addr_i;
   assign req.wdata = wr_data_i;
   assign req.wr = wr_i;
   assign req.rd = rd_i;

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   // Events and ticks decoded for this cycle
   logic int_tick;
   logic sel_tick;
   logic cnt_tick;
   logic wrap_evt;
   logic cap_evt;
   logic ti_evt;
   logic stat_rd;
   // One spare bit: the sum passes the accumulator width near the modulus
   logic [ctu_pkg::CTU_ACC_W:0] acc_sum;
   logic [ctu_pkg::CTU_ACC_W:0] acc_diff;
   logic [ctu_pkg::CTU_PRE_W-1:0] pre_mask;

   always_comb begin
      next_st = st;
      acc_sum = {1'b0, st.acc} + {1'b0, ctu_pkg::CTU_ACC_STEP};
      acc_diff = acc_sum - {1'b0, ctu_pkg::CTU_ACC_MOD};
      pre_mask = presc_mask(st.ctrl.presc);
      stat_rd = req.rd && hit(req.addr, ctu_pkg::CTU_ADDR_STATUS);

      // ***************************************************************
      // Count tick: accumulator and prescaler
      // ***************************************************************

      // Internal 28.7 MHz tick by fractional accumulation
      int_tick = 1'b0;
      if (acc_sum >= {1'b0, ctu_pkg::CTU_ACC_MOD}) begin
         next_st.acc = acc_diff[ctu_pkg::CTU_ACC_W-1:0];
         int_tick = 1'b1;
      end else begin
         next_st.acc = acc_sum[ctu_pkg::CTU_ACC_W-1:0];
      end

      // Prescaler runs on internal ticks while enabled
      // Restarting from zero on disable gives a full first period
      sel_tick = 1'b0;
      if (!st.ctrl.enable) begin
         next_st.pre = '0;
      end else if (int_tick) begin
         next_st.pre = st.pre + 6'h01;
      end
      if (st.ctrl.clk_ext) begin
         sel_tick = pin_rise[1]; // [RL3]
      end else begin
         sel_tick = int_tick && ((st.pre & pre_mask) == pre_mask); // [RL4]
      end
      cnt_tick = st.ctrl.enable && sel_tick; // [RL2]

      // ***************************************************************
      // Counter and capture
      // ***************************************************************

      // Counter with wrap at limit; software write takes priority
      wrap_evt = 1'b0;
      if (req.wr && hit(req.addr, ctu_pkg::CTU_ADDR_COUNT)) begin
         next_st.count = req.wdata[CNT_W-1:0]; // [RL13]
      end else if (cnt_tick) begin
         if (st.count == st.limit) begin
            next_st.count = '0; // [RL14] [RL16]
            wrap_evt = 1'b1;
         end else begin
            next_st.count = st.count + 16'h0001; // [RL1]
         end
      end

      // Capture on the selected edge while enabled
      cap_evt = 1'b0;
      if (st.ctrl.enable) begin
         case (st.ctrl.mode)
            ctu_pkg::CTU_MODE_CAP_RISE: cap_evt = pin_rise[0]; // [RL7]
            ctu_pkg::CTU_MODE_CAP_FALL: cap_evt = pin_fall[0]; // [RL8]
            default: cap_evt = 1'b0;
         endcase
      end

      // Event source: wrap in free modes, edge in capture modes
      ti_evt = is_free_mode(st.ctrl.mode) ? wrap_evt : cap_evt; // [RL6] [RL9] [RL16]

      // Capture register: hardware capture wins over a write
      // The count before this cycle's tick is the one the edge saw
      if (cap_evt) begin
         next_st.capture = st.count; // [RL7] [RL8]
      end else if (req.wr && hit(req.addr, ctu_pkg::CTU_ADDR_CAPTURE)) begin
         next_st.capture = req.wdata[CNT_W-1:0];
      end

      // ***************************************************************
      // Flags, task request and interrupt
      // ***************************************************************

      // Event flag: set wins; auto-clear when a task is selected
      // With a task selected the flag stands for one cycle only
      if (ti_evt) begin
         next_st.count_event_flag = 1'b1;
      end else if (st.ctrl.event_task_select != 3'h0) begin
         next_st.count_event_flag = 1'b0; // [RL11]
      end else if (stat_rd) begin
         next_st.count_event_flag = 1'b0; // [RL11]
      end

      // Wrap flag in every mode, cleared by status read
      if (wrap_evt) begin
         next_st.wrap_flag = 1'b1; // [RL12]
      end else if (stat_rd) begin
         next_st.wrap_flag = 1'b0; // [RL12]
      end

      // Task request pulse as the event flag is raised
      next_st.task_req = ti_evt ? task_decode(st.ctrl.event_task_select) : 4'h0; // [RL10]

      // Sticky interrupt status, cleared by read, set wins
      if (req.rd && hit(req.addr, ctu_pkg::CTU_ADDR_IRQ_STAT)) begin
         next_st.irq_stat = '0;
      end
      if (ti_evt) begin
         next_st.irq_stat[ctu_pkg::CTU_IRQ_EVENT] = 1'b1;
      end
      if (wrap_evt) begin
         next_st.irq_stat[ctu_pkg::CTU_IRQ_WRAP] = 1'b1;
      end
      if (cap_evt) begin
         next_st.irq_stat[ctu_pkg::CTU_IRQ_CAPTURE] = 1'b1;
      end
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

      // ***************************************************************
      // Register writes and read data
      // ***************************************************************

      // Configuration writes
      // Count and capture writes are merged with their hardware updates above
      if (req.wr) begin
         case (req.addr)
            ctu_pkg::CTU_ADDR_CTRL: begin
               next_st.ctrl = ctu_pkg::ctu_ctrl_s'(req.wdata[ctu_pkg::CTU_CTRL_W-1:0]);
            end
            ctu_pkg::CTU_ADDR_LIMIT: begin
               next_st.limit = req.wdata[CNT_W-1:0]; // [RL14]
            end
            ctu_pkg::CTU_ADDR_IRQ_MASK: begin
               next_st.irq_mask = req.wdata[ctu_pkg::CTU_IRQ_W-1:0];
            end
            default: begin
               next_st.irq_mask = next_st.irq_mask;
            end
         endcase
         next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      end

      // Read data one cycle after the strobe, zero otherwise
      // Narrow registers read back with zero upper bits
      next_st.rd_data = '0;
      if (req.rd) begin
         case (req.addr)
            ctu_pkg::CTU_ADDR_CTRL: begin
               next_st.rd_data = {3'h0, st.ctrl};
            end
            ctu_pkg::CTU_ADDR_STATUS: begin
               next_st.rd_data = {14'h0000, st.wrap_flag, st.count_event_flag};
            end
            ctu_pkg::CTU_ADDR_COUNT: begin
               next_st.rd_data = st.count; // [RL13]
            end
            ctu_pkg::CTU_ADDR_LIMIT: begin
               next_st.rd_data = st.limit;
            end
            ctu_pkg::CTU_ADDR_CAPTURE: begin
               next_st.rd_data = st.capture;
            end
            ctu_pkg::CTU_ADDR_IRQ_STAT: begin
               next_st.rd_data = {13'h0000, st.irq_stat};
            end
            ctu_pkg::CTU_ADDR_IRQ_MASK: begin
               next_st.rd_data = {13'h0000, st.irq_mask};
            end
            default: begin
               next_st.rd_data = '0;
            end
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************

   // Synchronous reset to defined values
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st <= '0;
         st.ctrl <= ctu_pkg::CTU_RST_CTRL;
         st.count <= ctu_pkg::CTU_RST_COUNT;
         st.limit <= ctu_pkg::CTU_RST_LIMIT;
         st.capture <= ctu_pkg::CTU_RST_CAPTURE;
         st.irq_mask <= ctu_pkg::CTU_RST_IRQ_MASK;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign rd_data_o = st.rd_data;
   assign event_task_req_o = st.task_req;
   assign irq_o = st.irq;

endmodule

// >>> verification/ctu_timer_asserts.sv
// Port-level concurrent checks for the capture timer unit
`timescale 1ns/1ns
module ctu_timer_asserts #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [ctu_pkg::CTU_ADDR_W-1:0] addr_i,
   input wire logic [ctu_pkg::CTU_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [ctu_pkg::CTU_DATA_W-1:0] rd_data_o,
   // Pins
   input wire logic capture_input_pin_i,
   input wire logic external_clock_pin_i,
   // Event task requests and interrupt
   input wire logic [ctu_pkg::CTU_TASK_W-1:0] event_task_req_o,
   input wire logic irq_o
);
   // ***************************************************************
   // Shadow copies of the mask and the task selector
   // ***************************************************************
   logic [2:0] mask_q;
   logic [2:0] sel_q;

   // Follow software writes so requests and interrupt can be judged
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mask_q <= 3'h0;
         sel_q <= 3'h0;
      end else if (wr_i) begin
         if (addr_i == ctu_pkg::CTU_ADDR_IRQ_MASK) mask_q <= wr_data_i[2:0];
         if (addr_i == ctu_pkg::CTU_ADDR_CTRL) sel_q <= wr_data_i[2:0];
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   read_idle_zero_a: assert property (!rd_i |=> rd_data_o == 16'h0000)
      else $error("read data not zero outside read slot");
   unmapped_read_a: assert property (rd_i && addr_i > 4'h6 |=> rd_data_o == 16'h0000)
      else $error("unmapped read not zero");
   status_width_a: assert property (rd_i && addr_i == 4'h1 |=> rd_data_o[15:2] == 14'h0)
      else $error("status upper bits not zero");
   ctrl_width_a: assert property (rd_i && addr_i == 4'h0 |=> rd_data_o[15:13] == 3'h0)
      else $error("control upper bits not zero");
   limit_back_a: assert property ((wr_i && addr_i == 4'h3 ##2 rd_i && addr_i == 4'h3)
      |=> rd_data_o == $past(wr_data_i, 3))
      else $error("limit read back differs from write");
   count_back_a: assert property ((wr_i && addr_i == 4'h2 ##2 rd_i && addr_i == 4'h2)
      |=> rd_data_o == $past(wr_data_i, 3) || rd_data_o == $past(wr_data_i, 3) + 16'h1
      || rd_data_o == 16'h0000)
      else $error("count read back differs from write");
   task_select_a: assert property (event_task_req_o != 4'h0
      |-> event_task_req_o == (4'h1 << (sel_q - 3'h1)))
      else $error("task request does not match selector");
   task_pulse_a: assert property (event_task_req_o != 4'h0 |=> event_task_req_o == 4'h0)
      else $error("task request longer than one cycle");
   irq_masked_a: assert property (irq_o |-> mask_q != 3'h0 || $past(mask_q) != 3'h0)
      else $error("interrupt high with all sources masked");
endmodule

bind ctu_timer ctu_timer_asserts #(.CNT_W(CNT_W)) u_chk (
   .mclk_i(mclk_i),
   .rst_n_i(rst_n_i),
   .addr_i(addr_i),
   .wr_data_i(wr_data_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rd_data_o(rd_data_o),
   .capture_input_pin_i(capture_input_pin_i),
   .external_clock_pin_i(external_clock_pin_i),
   .event_task_req_o(event_task_req_o),
   .irq_o(irq_o)
);

// >>> verification/ctu_timer_bench.sv
// Self-checking bench for the capture timer unit
`timescale 1ns/1ns
module ctu_timer_bench;
   // ***************************************************************
   // Signals and counters
   // ***************************************************************
   logic mclk_i;
   logic rst_n_i;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic cap_pin;
   logic ext_pin;
   logic [3:0] task_req;
   logic irq;
   logic [3:0] req_seen;
   logic [15:0] got;
   int mismatches;
   int cmp_count;
   int lim;

   ctu_timer DUT (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr),
      .wr_data_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rd_data_o(rdata),
      .capture_input_pin_i(cap_pin),
      .external_clock_pin_i(ext_pin),
      .event_task_req_o(task_req),
      .irq_o(irq)
   );

   // 250 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // Collect every task request pulse
   always @(posedge mclk_i) begin
      if (task_req != 4'h0) req_seen <= req_seen | task_req;
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   task automatic chk_rng(input string what, input int lo, input int hi, input logic [15:0] g);
      cmp_count++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         mismatches++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, g);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 got = rdata;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string what);
      rd_reg(a);
      chk(what, e, got);
   endtask

   // Interrupt level looked at once it has settled after the edge
   task automatic irq_chk(input string what, input logic e);
      #1;
      chk(what, 16'(e), 16'(irq));
   endtask

   // External clock pulses kept below 600 kHz
   task automatic pulse(input int n);
      @(posedge mclk_i);
      repeat (n) begin
         ext_pin <= 1'b1;
         repeat (210) @(posedge mclk_i);
         ext_pin <= 1'b0;
         repeat (210) @(posedge mclk_i);
      end
   endtask

   task automatic pin(input logic v);
      @(posedge mclk_i);
      cap_pin <= v;
      repeat (8) @(posedge mclk_i);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge mclk_i);
      mismatches++;
      tally_and_finish();
   end

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      rst_n_i = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      cap_pin = 1'b0;
      ext_pin = 1'b0;
      req_seen = 4'h0;
      mismatches = 0;
      cmp_count = 0;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // Reset values and an unmapped place
      wr_reg(4'h7, 16'hffff);
      for (int a = 0; a < 8; a++) begin
         rdc(4'(a), (a == 3) ? 16'hffff : 16'h0000, "reset value");
      end
      $display("reset test done");
      // External counting, wrap and flags
      wr_reg(4'h3, 16'h0002);
      rdc(4'h3, 16'h0002, "limit");
      wr_reg(4'h0, 16'h0018);
      pulse(2);
      rdc(4'h2, 16'h0002, "count");
      pulse(1);
      rdc(4'h2, 16'h0000, "count wrap");
      rdc(4'h1, 16'h0003, "status wrap");
      rdc(4'h1, 16'h0000, "status cleared");
      wr_reg(4'h2, 16'h0001);
      rdc(4'h2, 16'h0001, "count write");
      wr_reg(4'h0, 16'h0010);
      pulse(1);
      rdc(4'h2, 16'h0001, "count disabled");
      wr_reg(4'h1, 16'hffff);
      rdc(4'h1, 16'h0000, "status read only");
      $display("count test done");
      // Task selector values 1 to 5
      for (int s = 1; s < 6; s++) begin
         wr_reg(4'h2, 16'h0002);
         wr_reg(4'h0, 16'h0018 | 16'(s));
         req_seen <= 4'h0;
         pulse(1);
         chk("task request", (s < 5) ? 16'(1 << (s - 1)) : 16'h0000, 16'(req_seen));
         rd_reg(4'h1);
         chk("status auto clear", 16'h0002, got);
      end
      $display("task test done");
      // Capture on rising then falling edge, and mode 3
      wr_reg(4'h3, 16'h0005);
      wr_reg(4'h2, 16'h0003);
      wr_reg(4'h0, 16'h0098);
      rd_reg(4'h1);
      pin(1'b1);
      rdc(4'h4, 16'h0003, "capture rise");
      rdc(4'h1, 16'h0001, "status capture");
      pulse(3);
      rdc(4'h1, 16'h0002, "status capture wrap");
      pulse(1);
      rdc(4'h2, 16'h0001, "count after capture");
      wr_reg(4'h0, 16'h0118);
      wr_reg(4'h2, 16'h0004);
      pin(1'b0);
      rdc(4'h4, 16'h0004, "capture fall");
      rdc(4'h1, 16'h0001, "status fall");
      wr_reg(4'h2, 16'h0009);
      pin(1'b1);
      rdc(4'h4, 16'h0004, "capture rise ignored");
      wr_reg(4'h0, 16'h0198);
      wr_reg(4'h2, 16'h0005);
      pulse(1);
      rdc(4'h1, 16'h0003, "status mode 3");
      $display("capture test done");
      // Interrupt raised, cleared and masked
      wr_reg(4'h6, 16'h0002);
      wr_reg(4'h0, 16'h0018);
      rdc(4'h5, 16'h0007, "irq status all");
      repeat (2) @(posedge mclk_i);
      irq_chk("irq idle", 1'b0);
      wr_reg(4'h2, 16'h0005);
      pulse(1);
      irq_chk("irq raised", 1'b1);
      rdc(4'h5, 16'h0003, "irq status");
      repeat (2) @(posedge mclk_i);
      irq_chk("irq cleared", 1'b0);
      wr_reg(4'h6, 16'h0000);
      wr_reg(4'h2, 16'h0005);
      pulse(1);
      irq_chk("irq masked", 1'b0);
      rdc(4'h5, 16'h0003, "irq status masked");
      $display("interrupt test done");
      // Internal clock with each prescale
      wr_reg(4'h3, 16'hffff);
      for (int p = 0; p < 4; p++) begin
         wr_reg(4'h2, 16'h0000);
         wr_reg(4'h0, 16'h0008 | 16'(p << 5));
         repeat (4000) @(posedge mclk_i);
         wr_reg(4'h0, 16'h0000);
         rd_reg(4'h2);
         lim = 1148000 / (2500 << (2 * p));
         chk_rng("internal count", lim - 2, lim + 2, got);
      end
      $display("prescale test done");
      tally_and_finish();
   end
endmodule
